// file: rtl/tchcfg_pkg.sv
// shared constants and types for the touch channel timing block
package tchcfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHANNEL_SAMPLE_ENABLE = 8'h21; // per-input sample enables
  localparam logic [7:0] ADDR_HOLD_AND_REPEAT_TIMING = 8'h22; // max hold and repeat codes
  localparam logic [7:0] ADDR_PRESS_HOLD_THRESHOLD = 8'h23; // minimum press code

  localparam logic [7:0] RST_CHANNEL_SAMPLE_ENABLE = 8'hff; // all inputs sampled
  localparam logic [7:0] RST_HOLD_AND_REPEAT_TIMING = 8'ha4; // 5600 ms / 175 ms
  localparam logic [3:0] RST_PRESS_HOLD_THRESHOLD = 4'h7; // 280 ms

  // field positions inside the timing register
  localparam int MAX_HOLD_TIME_LSB = 4; // max_hold_time in bits 7:4
  localparam int REPEAT_INTERVAL_LSB = 0; // repeat_interval in bits 3:0

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // core clock period
  localparam int TICK_TIME_MS = 35; // common timebase step
  localparam int TICK_CYCLES_DEF = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLOT_TIME_NS = 1280000; // one sample slot, 1.28 ms
  localparam int SLOT_CYCLES_DEF = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int CYCLE_TIME_MS = 70; // whole sampling cycle
  localparam logic [1:0] CYCLE_TICKS = 2'(CYCLE_TIME_MS / TICK_TIME_MS);
  localparam int NUM_CH = 8; // touch inputs
  localparam logic [8:0] HOLD_TICKS_MAX = 9'h1ff; // saturation of hold timer

  // max hold decode, in milliseconds
  localparam int MAX_HOLD_MS [16] = '{560, 840, 1120, 1400, 1680, 2240, 2800, 3360,
                                      3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200};

  // ticks that must be exceeded before recalibration
  function automatic logic [8:0] maxHoldTicks(input logic [3:0] code);
    maxHoldTicks = 9'(MAX_HOLD_MS[code] / TICK_TIME_MS);
  endfunction

  // sampler sequencing, gray coded
  typedef enum logic {
    SMP_WAIT = 1'b0,
    SMP_SCAN = 1'b1
  } tchcfg_sampler_t;

endpackage

// file: rtl/tchcfg_tick_div.sv
// divider producing the one-cycle 35 ms timebase enable
`timescale 1ns/1ps
module tchcfg_tick_div #(
  parameter int TICK_CYCLES = tchcfg_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // timebase
  output logic tick
);

  import tchcfg_pkg::*;

  // divider state, one registered copy
  typedef struct packed {
    logic [21:0] count; // cycles since last tick
    logic pulse; // registered timebase pulse
  } tchcfg_div_t;

  tchcfg_div_t div; // registered state
  tchcfg_div_t next_div; // next state

  // ----------------------------------------------------------------
  // free running divider
  // ----------------------------------------------------------------
  // pulse lasts one cycle, so no consumer can count it twice
  always_comb begin
    next_div = div;
    next_div.pulse = 1'b0;
    if (div.count == 22'(TICK_CYCLES - 1)) begin
      next_div.count = 22'h000000; // wrap and pulse
      next_div.pulse = 1'b1;
    end else begin
      next_div.count = div.count + 22'h000001; // keep counting
    end
  end

  // state register, restarts the timebase on reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end

  // ----------------------------------------------------------------
  // output, straight from the flop
  // ----------------------------------------------------------------
  assign tick = div.pulse;

endmodule

// file: rtl/tchcfg_top.sv
// touch channel sampling enables, hold timing and auto repeat
`timescale 1ns/1ps
// Overview of operation
// - enabled inputs sampled, disabled skipped, reset all on
// - enable bits map input eight down to one
// - sampling cycle length fixed regardless of enables
// - recalibrate after touch exceeds max hold time
// - auto repeat interrupts spaced by repeat interval
// - repeat code n gives (n+1) x 35 ms
// - touch longer than press time is press-and-hold
// - touch up to press time is plain touch
// - press time uses the same 35 ms table
// - hold recalibration only while global enable set
module tchcfg_top
  import tchcfg_pkg::*;
#(
  parameter int TICK_CYCLES = tchcfg_pkg::TICK_CYCLES_DEF,
  parameter int SLOT_CYCLES = tchcfg_pkg::SLOT_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // detection and global control
  input wire logic [7:0] touchDetected,
  input wire logic [7:0] autoRepeatEn,
  input wire logic holdRecalEnable,
  // sampler outputs
  output logic [7:0] sampleEnable,
  output logic cycleStart,
  output logic [7:0] sampleStrobe,
  // touch timing events
  output logic [7:0] recalRequest,
  output logic [7:0] pressHold,
  output logic [7:0] shortTouch,
  output logic [7:0] repeatIrq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] chEnable; // channel_sample_enable
    logic [7:0] timing; // hold_and_repeat_timing
    logic [3:0] pressCode; // press_hold_threshold low nibble
    logic [7:0] rdData; // read return
    tchcfg_sampler_t smp; // sampler phase
    logic [1:0] cycTicks; // ticks into sampling cycle
    logic [2:0] slot; // current sample slot
    logic [16:0] slotCnt; // cycles within slot
    logic cycStart; // cycle start pulse
    logic [7:0] strobe; // per-input sample pulse
    logic [7:0][8:0] holdTicks; // held-touch timers
    logic [7:0][4:0] rptCnt; // ticks since last repeat
    logic [7:0] held; // press-and-hold flags
    logic [7:0] recalDone; // one recal per touch
    logic [7:0] touchPrev; // last touch level
    logic [7:0] recalPulse; // recal request pulses
    logic [7:0] shortPulse; // short touch pulses
    logic [7:0] rptPulse; // repeat interrupt pulses
  } tchcfg_state_t;

  tchcfg_state_t s; // registered state
  tchcfg_state_t next_s; // next state
  logic tick; // 35 ms enable

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  tchcfg_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] maxLim;
    logic [4:0] pressLim;
    logic [4:0] rptLim;
    logic [8:0] nh;
    logic [4:0] nr;
    logic t;
    next_s = s;
    maxLim = maxHoldTicks(s.timing[MAX_HOLD_TIME_LSB +: 4]);
    pressLim = {1'b0, s.pressCode} + 5'h01;
    rptLim = {1'b0, s.timing[REPEAT_INTERVAL_LSB +: 4]} + 5'h01;
    nh = 9'h000;
    nr = 5'h00;
    t = 1'b0;
    next_s.cycStart = 1'b0;
    next_s.strobe = 8'h00;
    next_s.recalPulse = 8'h00;
    next_s.shortPulse = 8'h00;
    next_s.rptPulse = 8'h00;

    // register writes
    if (regWrEn) begin
      unique case (regAddr)
        ADDR_CHANNEL_SAMPLE_ENABLE: next_s.chEnable = regWrData;
        ADDR_HOLD_AND_REPEAT_TIMING: next_s.timing = regWrData;
        ADDR_PRESS_HOLD_THRESHOLD: next_s.pressCode = regWrData[3:0];
        default: ; // unmapped writes ignored
      endcase
    end

    // register reads, unmapped reads return zero
    if (regRdEn) begin
      unique case (regAddr)
        ADDR_CHANNEL_SAMPLE_ENABLE: next_s.rdData = s.chEnable;
        ADDR_HOLD_AND_REPEAT_TIMING: next_s.rdData = s.timing;
        ADDR_PRESS_HOLD_THRESHOLD: next_s.rdData = {4'h0, s.pressCode};
        default: next_s.rdData = 8'h00;
      endcase
    end

    // sampling cycle length counted in ticks only
    if (tick) begin
      if (s.cycTicks == CYCLE_TICKS - 2'h1) begin
        next_s.cycTicks = 2'h0;
        next_s.cycStart = 1'b1;
        next_s.smp = SMP_SCAN;
        next_s.slot = 3'h0;
        next_s.slotCnt = 17'h00000;
      end else begin
        next_s.cycTicks = s.cycTicks + 2'h1;
      end
    end

    // every slot is walked; disabled ones stay silent
    unique case (s.smp)
      SMP_WAIT: ; // idle until next cycle
      SMP_SCAN: begin
        if (s.slotCnt == 17'h00000) begin
          next_s.strobe[s.slot] = s.chEnable[s.slot];
        end
        if (s.slotCnt == 17'(SLOT_CYCLES - 1)) begin
          next_s.slotCnt = 17'h00000;
          next_s.slot = s.slot + 3'h1;
          if (s.slot == 3'h7) begin
            next_s.smp = SMP_WAIT; // scan done, rest of cycle idle
          end
        end else begin
          next_s.slotCnt = s.slotCnt + 17'h00001;
        end
      end
    endcase

    // per-channel hold timing
    for (int i = 0; i < NUM_CH; i++) begin
      t = touchDetected[i] & s.chEnable[i];
      next_s.touchPrev[i] = t;
      if (!t) begin
        if (s.touchPrev[i] && autoRepeatEn[i] && !s.held[i]) begin
          next_s.shortPulse[i] = 1'b1;
        end
        next_s.holdTicks[i] = 9'h000;
        next_s.held[i] = 1'b0;
        next_s.recalDone[i] = 1'b0;
        next_s.rptCnt[i] = 5'h00;
      end else if (tick) begin
        nh = (s.holdTicks[i] == HOLD_TICKS_MAX) ? s.holdTicks[i] : s.holdTicks[i] + 9'h001;
        next_s.holdTicks[i] = nh;
        if (holdRecalEnable && !s.recalDone[i] && nh > maxLim) begin
          next_s.recalPulse[i] = 1'b1;
          next_s.recalDone[i] = 1'b1;
        end
        if (autoRepeatEn[i] && !s.held[i] && nh > {4'h0, pressLim}) begin
          next_s.held[i] = 1'b1;
          next_s.rptPulse[i] = 1'b1;
          next_s.rptCnt[i] = 5'h00;
        end else if (s.held[i] && autoRepeatEn[i]) begin
          nr = s.rptCnt[i] + 5'h01;
          if (nr >= rptLim) begin
            next_s.rptPulse[i] = 1'b1;
            next_s.rptCnt[i] = 5'h00;
          end else begin
            next_s.rptCnt[i] = nr;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.chEnable <= RST_CHANNEL_SAMPLE_ENABLE;
      s.timing <= RST_HOLD_AND_REPEAT_TIMING;
      s.pressCode <= RST_PRESS_HOLD_THRESHOLD;
      s.smp <= SMP_WAIT;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign regRdData = s.rdData;
  assign sampleEnable = s.chEnable;
  assign cycleStart = s.cycStart;
  assign sampleStrobe = s.strobe;
  assign recalRequest = s.recalPulse;
  assign pressHold = s.held;
  assign shortTouch = s.shortPulse;
  assign repeatIrq = s.rptPulse;

endmodule

// file: test/tchcfg_sva.sv
// property checker for the touch channel timing block
`timescale 1ns/1ps
module tchcfg_sva #(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // inputs
  input wire logic [7:0] touchDetected,
  input wire logic [7:0] autoRepeatEn,
  input wire logic holdRecalEnable,
  // outputs
  input wire logic [7:0] sampleEnable,
  input wire logic cycleStart,
  input wire logic [7:0] sampleStrobe,
  input wire logic [7:0] recalRequest,
  input wire logic [7:0] pressHold,
  input wire logic [7:0] shortTouch,
  input wire logic [7:0] repeatIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int gap; // cycles since cycle start, -1 before the first
  // cycle length counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) gap <= -1;
    else if (cycleStart) gap <= 0;
    else if (gap >= 0) gap <= gap + 1;
  end
  a_skip_off: assert property ((sampleStrobe & ~$past(sampleEnable)) == 8'h00)
    else $error("strobe on disabled input");
  a_slot_one: assert property (cycleStart |=> sampleStrobe[0] == $past(sampleEnable[0]))
    else $error("first slot wrong");
  a_cycle_fixed: assert property (cycleStart && gap >= 0 |-> gap == 2 * TICK_CYCLES - 1)
    else $error("cycle length changed");
  a_recal_gated: assert property (recalRequest != 8'h00 |-> $past(holdRecalEnable))
    else $error("recal while disabled");
  a_recal_pulse: assert property ((recalRequest & $past(recalRequest)) == 8'h00)
    else $error("recal repeated");
  a_hold_rpt: assert property ((pressHold & ~$past(pressHold) & ~$past(autoRepeatEn)) == 8'h00)
    else $error("hold without auto repeat");
  a_short_plain: assert property ((shortTouch & $past(pressHold)) == 8'h00)
    else $error("short touch after hold");
  a_repeat_held: assert property ((repeatIrq & ~pressHold) == 8'h00)
    else $error("repeat outside hold");
  a_hold_drop: assert property (pressHold[0] && !touchDetected[0] |=> !pressHold[0])
    else $error("hold kept after release");
  c_repeat: cover property (repeatIrq[0]);
  c_recal: cover property (recalRequest[2]);
  c_short: cover property (shortTouch[0]);
endmodule
bind tchcfg_top tchcfg_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.core_clk(core_clk), .rst(rst),
  .touchDetected(touchDetected), .autoRepeatEn(autoRepeatEn), .holdRecalEnable(holdRecalEnable),
  .sampleEnable(sampleEnable), .cycleStart(cycleStart), .sampleStrobe(sampleStrobe),
  .recalRequest(recalRequest), .pressHold(pressHold), .shortTouch(shortTouch),
  .repeatIrq(repeatIrq));

// file: test/tchcfg_host.sv
// host software model driving the register port
`timescale 1ns/1ps
module tchcfg_host (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  // idle bus
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // one write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask
  // read strobe, data taken once registered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(posedge core_clk);
    #1 d = regRdData;
  endtask
endmodule

// file: test/touch_channel_timing_config_test.sv
// self-checking bench for the touch channel timing block
`timescale 1ns/1ps
module touch_channel_timing_config_test;
  import tchcfg_pkg::*;
  localparam int TK = 20; // shortened tick
  logic [23:0] rows [4] = '{24'h215a5a, 24'h223c3c, 24'h23ff0f, 24'h301200}; // addr wr rd
  logic [7:0] en [2] = '{8'h81, 8'h00};
  logic [7:0] rp [3] = '{8'h47, 8'h00, 8'hf2}; // repeat code, press code
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic holdRecalEnable = 1'b0;
  logic [7:0] touchDetected = 8'h00;
  logic [7:0] autoRepeatEn = 8'h00;
  logic [7:0] regAddr, regWrData, regRdData, d, acc;
  logic regWrEn, regRdEn, cycleStart;
  logic [7:0] sampleEnable, sampleStrobe, recalRequest, pressHold, shortTouch, repeatIrq;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  always #5 core_clk = ~core_clk;
  tchcfg_host host (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  tchcfg_top #(.TICK_CYCLES(TK), .SLOT_CYCLES(2)) dut (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .touchDetected(touchDetected), .autoRepeatEn(autoRepeatEn),
    .holdRecalEnable(holdRecalEnable), .sampleEnable(sampleEnable), .cycleStart(cycleStart),
    .sampleStrobe(sampleStrobe), .recalRequest(recalRequest), .pressHold(pressHold),
    .shortTouch(shortTouch), .repeatIrq(repeatIrq));
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic results();
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // event lands within a tick window
  function automatic logic [15:0] inwin(input int k, input int t);
    return 16'(k > (t - 1) * TK && k <= t * TK + 2);
  endfunction
  task automatic drv(input logic [7:0] t, input logic [7:0] a, input logic h);
    @(posedge core_clk);
    touchDetected <= t;
    autoRepeatEn <= a;
    holdRecalEnable <= h;
  endtask
  // cycles until selected event on mask, 0 if none
  task automatic waitEv(input int sel, input logic [7:0] m, input int lim, output int k);
    logic [7:0] v;
    k = 0;
    repeat (lim) begin
      @(posedge core_clk);
      #1;
      k++;
      case (sel)
        0: v = {7'h00, cycleStart};
        1: v = pressHold;
        2: v = repeatIrq;
        3: v = recalRequest;
        default: v = shortTouch;
      endcase
      if ((v & m) !== 8'h00) return;
    end
    k = 0;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      host.rd(rows[i][23:16], d);
      chk(d, rows[i][7:0]);
    end
    foreach (en[i]) begin
      host.wr(8'h21, en[i]);
      waitEv(0, 8'h01, 100, n);
      acc = 8'h00;
      n = 0;
      do begin
        @(posedge core_clk);
        #1;
        n++;
        acc |= sampleStrobe;
      end while (!cycleStart && n < 100);
      chk(sampleEnable, en[i]);
      chk(acc, en[i]);
      chk(16'(n), 16'(2 * TK));
    end
    // second reset restores defaults
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    host.rd(8'h21, d);
    chk(d, 8'hff);
    host.rd(8'h22, d);
    chk(d, 8'ha4);
    host.rd(8'h23, d);
    chk(d, 8'h07);
    foreach (rp[i]) begin
      host.wr(8'h22, {4'ha, rp[i][7:4]});
      host.wr(8'h23, {4'h0, rp[i][3:0]});
      drv(8'h01, 8'h01, 1'b0);
      waitEv(1, 8'h01, 400, n);
      chk(inwin(n, rp[i][3:0] + 2), 16'h1);
      waitEv(2, 8'h01, 400, n);
      chk(16'(n), 16'((rp[i][7:4] + 1) * TK));
      drv(8'h00, 8'h01, 1'b0);
      repeat (2) @(posedge core_clk);
      #1;
      chk(pressHold, 8'h00);
      waitEv(2, 8'h01, 100, n);
      chk(16'(n), 16'h0);
    end
    // short touch, then a touch on a skipped input
    host.wr(8'h23, 8'h07);
    drv(8'h01, 8'h01, 1'b0);
    repeat (3 * TK) @(posedge core_clk);
    drv(8'h00, 8'h01, 1'b0);
    waitEv(4, 8'h01, 4, n);
    chk(16'(n != 0), 16'h1);
    host.wr(8'h21, 8'hfe);
    drv(8'h01, 8'h01, 1'b0);
    waitEv(1, 8'h01, 12 * TK, n);
    chk(16'(n), 16'h0);
    drv(8'h00, 8'h01, 1'b0);
    host.wr(8'h21, 8'hff);
    // max hold recalibration, enabled then disabled
    host.wr(8'h22, 8'h04);
    drv(8'h04, 8'h00, 1'b1);
    waitEv(3, 8'h04, 400, n);
    chk(inwin(n, 17), 16'h1);
    waitEv(3, 8'h04, 200, n);
    chk(16'(n), 16'h0);
    drv(8'h00, 8'h00, 1'b0);
    drv(8'h04, 8'h00, 1'b0);
    waitEv(3, 8'h04, 400, n);
    chk(16'(n), 16'h0);
    drv(8'h00, 8'h00, 1'b0);
    results();
  end
endmodule
